// file: design/rpq_consts.svh
// Register indices, field positions, reset values and counts of the qualifier
`ifndef RPQ_CONSTS_SVH
`define RPQ_CONSTS_SVH
`define RPQ_IX_ST1      7'h03
`define RPQ_IX_ST2      7'h04
`define RPQ_IX_CTRL1    7'h07
`define RPQ_IX_CTRL2    7'h08
`define RPQ_IX_DAC      7'h30
`define RPQ_IX_HC1      7'h32
`define RPQ_IX_HC2      7'h33
`define RPQ_IX_PRE      7'h34
`define RPQ_IX_PDC      7'h35
`define RPQ_IX_SYNC3    7'h36
`define RPQ_IX_SYNC2    7'h37
`define RPQ_IX_SYNC1    7'h38
`define RPQ_IX_SYNC0    7'h39
`define RPQ_IX_TXHD3    7'h3a
`define RPQ_IX_PKLEN    7'h3e
`define RPQ_IX_CHHD3    7'h3f
`define RPQ_IX_HDEN3    7'h43
`define RPQ_IX_HDEN0    7'h46
`define RPQ_IX_RXHD3    7'h47
`define RPQ_IX_RXHD2    7'h48
`define RPQ_IX_RXHD1    7'h49
`define RPQ_IX_RXHD0    7'h4a
`define RPQ_IX_RXPLEN   7'h4b
`define RPQ_IX_INVW     7'h60
`define RPQ_IX_MOD      7'h70
`define RPQ_IX_AFTHR    7'h7c
`define RPQ_B_TXON      3
`define RPQ_B_AUTOTX    3
`define RPQ_B_CRCDONLY  5
`define RPQ_B_FIXPKLEN  3
`define RPQ_B_WHITE     0
`define RPQ_B_MANCH     1
`define RPQ_B_MANINV    2
`define RPQ_RST_HC1     8'h0c
`define RPQ_RST_HC2     8'h22
`define RPQ_RST_PRE     8'h08
`define RPQ_RST_PDC     8'h2a
`define RPQ_RST_SYNC3   8'h2d
`define RPQ_RST_SYNC2   8'hd4
`define RPQ_RST_HDEN    8'hff
`define RPQ_PN9_SEED    9'h1ff
`define RPQ_SYNC_XTRA   6'h04
`endif

// file: design/rpq_pkg.sv
// Types of the radio packet qualifier
package rpq_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PRE  = 3'b001,
		S_SYNC = 3'b010,
		S_HDR  = 3'b011,
		S_LEN  = 3'b100,
		S_DATA = 3'b101
	} rpq_st_t;
endpackage

// file: design/rpq_top.sv
// Radio packet qualifier: framing, whitening, Manchester, preamble and sync
`timescale 1ns/100ps
`default_nettype none
`include "rpq_consts.svh"
module rpq_top #(
	parameter int FIFO_DEPTH = 64,
	parameter int LVL_W      = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [11:0]      paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             sym_tick,
	input  wire logic             rx_sym,
	input  wire logic             rx_en,
	input  wire logic [7:0]       tx_byte,
	input  wire logic             tx_wr,
	input  wire logic [LVL_W-1:0] tx_level,
	output logic                  tx_sym,
	output logic                  tx_active,
	output logic                  tx_rd,
	output logic                  tx_rewind,
	output logic      [7:0]       rx_byte,
	output logic                  rx_valid,
	output logic                  crc_clr,
	output logic                  crc_stb,
	output logic                  crc_bit,
	output logic                  pre_det,
	output logic                  pre_inv
);
	logic [7:0]  regs_q [0:127];
	logic [7:0]  st1_q, st2_q, rd_val, rxplen_q, pklen;
	logic [31:0] rxhd_q, sync_w, txhd, chhd, hden;
	logic [6:0]  idx;
	logic        hit, acc, wr_en, rd_done;
	logic        whiten, manch, inv, crcdonly, fixpk, txon, autotx;
	logic [1:0]  synclen;
	logic [2:0]  hdlen, snb;
	logic [3:0]  bcen, hdch, invw;
	logic [4:0]  preath;
	logic [8:0]  prealen, pl;

	assign idx     = paddr[8:2];
	assign hit     = (paddr[11:9] == 3'h0);
	assign acc     = psel & penable & pready;
	assign wr_en   = acc & pwrite & hit;
	assign rd_done = acc & ~pwrite & hit;

	assign whiten   = regs_q[`RPQ_IX_MOD][`RPQ_B_WHITE];
	assign manch    = regs_q[`RPQ_IX_MOD][`RPQ_B_MANCH];
	assign inv      = regs_q[`RPQ_IX_MOD][`RPQ_B_MANINV];
	assign crcdonly = regs_q[`RPQ_IX_DAC][`RPQ_B_CRCDONLY];
	assign fixpk    = regs_q[`RPQ_IX_HC2][`RPQ_B_FIXPKLEN];
	assign txon     = regs_q[`RPQ_IX_CTRL1][`RPQ_B_TXON];
	assign autotx   = regs_q[`RPQ_IX_CTRL2][`RPQ_B_AUTOTX];
	assign synclen  = regs_q[`RPQ_IX_HC2][2:1];
	assign hdlen    = regs_q[`RPQ_IX_HC2][6:4];
	assign bcen     = regs_q[`RPQ_IX_HC1][7:4];
	assign hdch     = regs_q[`RPQ_IX_HC1][3:0];
	assign preath   = regs_q[`RPQ_IX_PDC][7:3];
	assign invw     = regs_q[`RPQ_IX_INVW][7:4];
	assign pklen    = regs_q[`RPQ_IX_PKLEN];
	assign prealen  = {regs_q[`RPQ_IX_HC2][0], regs_q[`RPQ_IX_PRE]};
	assign pl       = (prealen == 9'h000) ? 9'h001 : prealen;
	assign snb      = {1'b0, synclen} + 3'h1;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_word
			assign sync_w[31-8*g -: 8] = regs_q[`RPQ_IX_SYNC3 + 7'(g)];
			assign txhd[31-8*g -: 8]   = regs_q[`RPQ_IX_TXHD3 + 7'(g)];
			assign chhd[31-8*g -: 8]   = regs_q[`RPQ_IX_CHHD3 + 7'(g)];
			assign hden[31-8*g -: 8]   = regs_q[`RPQ_IX_HDEN3 + 7'(g)];
		end
	endgenerate

	function automatic logic [7:0] rst_val(input logic [6:0] i);
		case (i)
		`RPQ_IX_HC1:   rst_val = `RPQ_RST_HC1;
		`RPQ_IX_HC2:   rst_val = `RPQ_RST_HC2;
		`RPQ_IX_PRE:   rst_val = `RPQ_RST_PRE;
		`RPQ_IX_PDC:   rst_val = `RPQ_RST_PDC;
		`RPQ_IX_SYNC3: rst_val = `RPQ_RST_SYNC3;
		`RPQ_IX_SYNC2: rst_val = `RPQ_RST_SYNC2;
		default:       rst_val = (i >= `RPQ_IX_HDEN3 && i <= `RPQ_IX_HDEN0) ?
		                         `RPQ_RST_HDEN : 8'h00;
		endcase
	endfunction

	// Field order shared by both directions
	function automatic rpq_pkg::rpq_st_t next_fld(
		input rpq_pkg::rpq_st_t st, input logic [7:0] ln, input logic more);
		next_fld = rpq_pkg::S_IDLE;
		if (st == rpq_pkg::S_PRE)
			next_fld = rpq_pkg::S_SYNC;
		else if (st == rpq_pkg::S_SYNC && hdlen != 3'h0)
			next_fld = rpq_pkg::S_HDR;
		else if ((st == rpq_pkg::S_SYNC || st == rpq_pkg::S_HDR) && !fixpk)
			next_fld = rpq_pkg::S_LEN;
		else if ((st != rpq_pkg::S_DATA && ln != 8'h00) || more)
			next_fld = rpq_pkg::S_DATA;
	endfunction

	// Register file; transmit start clears the command bit
	logic tx_go;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 128; i++)
				regs_q[i] <= rst_val(7'(i));
		end else begin
			if (wr_en && idx != `RPQ_IX_ST1 && idx != `RPQ_IX_ST2 &&
			    !(idx >= `RPQ_IX_RXHD3 && idx <= `RPQ_IX_RXPLEN))
				regs_q[idx] <= pwdata[7:0];
			if (tx_go)
				regs_q[`RPQ_IX_CTRL1][`RPQ_B_TXON] <= 1'b0;
		end
	end

	always_comb begin
		case (idx)
		`RPQ_IX_ST1:    rd_val = st1_q;
		`RPQ_IX_ST2:    rd_val = st2_q;
		`RPQ_IX_RXHD3:  rd_val = rxhd_q[31:24];
		`RPQ_IX_RXHD2:  rd_val = rxhd_q[23:16];
		`RPQ_IX_RXHD1:  rd_val = rxhd_q[15:8];
		`RPQ_IX_RXHD0:  rd_val = rxhd_q[7:0];
		`RPQ_IX_RXPLEN: rd_val = rxplen_q;
		default:        rd_val = regs_q[idx];
		endcase
	end

	// One wait state: data is captured on the same edge that pready rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				pslverr <= ~hit;
				prdata  <= hit ? {24'h0, rd_val} : 32'h0;
			end
		end
	end

	// Transmit path
	rpq_pkg::rpq_st_t tst_q, nf_st;
	logic [31:0] tsh_q, nf_sh;
	logic [11:0] tcnt_q, nf_cnt;
	logic [7:0]  tbyt_q;
	logic [8:0]  tlfsr_q;
	logic        thalf_q, tbit_q, reload_q, nf_pop, tb, twb, tstep, tx_done;

	always_comb begin
		nf_st  = next_fld(tst_q, pklen,
		                  tst_q == rpq_pkg::S_DATA && tbyt_q > 8'h01);
		nf_sh  = 32'h0;
		nf_cnt = 12'h0;
		nf_pop = 1'b0;
		case (nf_st)
		rpq_pkg::S_SYNC: begin
			nf_sh  = sync_w;
			nf_cnt = {6'h0, snb, 3'h0};
		end
		rpq_pkg::S_HDR: begin
			nf_sh  = txhd;
			nf_cnt = {6'h0, hdlen, 3'h0};
		end
		rpq_pkg::S_LEN: begin
			nf_sh  = {pklen, 24'h0};
			nf_cnt = 12'h008;
		end
		rpq_pkg::S_DATA: begin
			nf_sh  = {tx_byte, 24'h0};
			nf_cnt = 12'h008;
			nf_pop = 1'b1;
		end
		default: ;
		endcase
	end

	// auto start above the almost-full level
	assign tx_go = (tst_q == rpq_pkg::S_IDLE) && !thalf_q &&
	               (txon || (autotx &&
	                tx_level > regs_q[`RPQ_IX_AFTHR][LVL_W-1:0]));
	// preamble bit from the even count, first bit zero
	assign tb    = (tst_q == rpq_pkg::S_PRE) ? tcnt_q[0] : tsh_q[31];
	assign twb   = tb ^ (tst_q == rpq_pkg::S_DATA && whiten && tlfsr_q[0]);
	assign tstep = sym_tick && !thalf_q && tst_q != rpq_pkg::S_IDLE;
	// packet ends after the last programmed byte
	assign tx_done = tstep && tcnt_q == 12'h001 && nf_st == rpq_pkg::S_IDLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tst_q     <= rpq_pkg::S_IDLE;
			tsh_q     <= 32'h0;
			tcnt_q    <= 12'h0;
			tbyt_q    <= 8'h0;
			tlfsr_q   <= `RPQ_PN9_SEED;
			thalf_q   <= 1'b0;
			tbit_q    <= 1'b0;
			reload_q  <= 1'b0;
			tx_sym    <= 1'b0;
			tx_active <= 1'b0;
			tx_rd     <= 1'b0;
			tx_rewind <= 1'b0;
		end else begin
			tx_rd     <= 1'b0;
			tx_rewind <= 1'b0;
			if (tx_wr)
				reload_q <= 1'b1;
			if (tx_go) begin
				tst_q     <= rpq_pkg::S_PRE;
				tcnt_q    <= {pl, 3'h0};
				tbyt_q    <= pklen;
				tx_active <= 1'b1;
				reload_q  <= 1'b0;
				// replay the FIFO on a txon start when nothing new was loaded
				// only when the packet fits the FIFO
				tx_rewind <= txon && !reload_q && !tx_wr &&
				             {24'h0, pklen} <= FIFO_DEPTH;
			end else if (sym_tick && thalf_q) begin
				// second symbol is the complement, inverted if set
				tx_sym  <= ~tbit_q ^ inv;
				thalf_q <= 1'b0;
				if (tst_q == rpq_pkg::S_IDLE)
					tx_active <= 1'b0;
			end else if (tstep) begin
				tbit_q  <= twb;
				// Manchester sends two symbols per bit
				tx_sym  <= manch ? (twb ^ inv) : twb;
				thalf_q <= manch;
				if (tst_q == rpq_pkg::S_DATA)
					tlfsr_q <= {tlfsr_q[0] ^ tlfsr_q[5], tlfsr_q[8:1]};
				if (tcnt_q > 12'h001) begin
					tcnt_q <= tcnt_q - 12'h001;
					tsh_q  <= {tsh_q[30:0], 1'b0};
				end else begin
					tst_q  <= nf_st;
					tsh_q  <= nf_sh;
					tcnt_q <= nf_cnt;
					tx_rd  <= nf_pop;
					// generator restarts at the first payload bit
					if (nf_st == rpq_pkg::S_DATA && tst_q != rpq_pkg::S_DATA)
						tlfsr_q <= `RPQ_PN9_SEED;
					if (tst_q == rpq_pkg::S_DATA)
						tbyt_q <= tbyt_q - 8'h01;
					if (nf_st == rpq_pkg::S_IDLE && !manch)
						tx_active <= 1'b0;
				end
			end
		end
	end

	// Receive path; symbols come from the modem in this clock domain
	rpq_pkg::rpq_st_t rst_q, rnf;
	logic [31:0] rsh_q, want, msk;
	logic [8:0]  rlfsr_q;
	logic [7:0]  pre_cnt_q, pre_nx, rcnt_q, rcnt_nx, rbyte;
	logic [5:0]  win_q, tmo_q;
	logic [2:0]  rbits_q;
	logic [1:0]  hidx;
	logic        rhalf_q, rfirst_q, rlast_q, inv_done_q, tmo_run_q;
	logic        rx_stb, rx_b, rb_in, pre_hit, inv_hit, sync_hit, tmo_hit;
	logic        bdone, hdr_bad, fend;

	// first symbol of a pair carries the bit, inverted if set
	assign rx_stb  = sym_tick && rx_en && (!manch || rhalf_q);
	assign rx_b    = manch ? (rfirst_q ^ inv) : rx_sym;
	assign rb_in   = rx_b ^ (rst_q == rpq_pkg::S_DATA && whiten && rlfsr_q[0]);
	assign rbyte   = {rsh_q[6:0], rb_in};
	assign pre_nx  = (rx_b != rlast_q) ?
	                 ((pre_cnt_q == 8'hff) ? 8'hff : pre_cnt_q + 8'h01) : 8'h01;
	assign pre_hit = pre_nx >= {1'b0, preath, 2'b00};
	// window of four-bit units without a preamble
	assign inv_hit = invw != 4'h0 && !inv_done_q &&
	                 (win_q + 6'h01) == {invw, 2'b00};
	// compare only the selected top bytes of the sync word
	assign want    = sync_w >> {3'h3 - {1'b0, synclen}, 3'h0};
	assign msk     = 32'hffffffff >> {3'h3 - {1'b0, synclen}, 3'h0};
	// received bits shift in, byte 3 lands highest
	assign sync_hit = (({rsh_q[30:0], rx_b} ^ want) & msk) == 32'h0;
	assign tmo_hit = (tmo_q + 6'h01) == ({snb, 3'h0} + `RPQ_SYNC_XTRA);
	assign bdone   = rbits_q == 3'h7;
	assign rcnt_nx = rcnt_q + 8'h01;
	assign hidx    = 2'h3 - rcnt_q[1:0];
	// masked compare per checked byte, broadcast FFh
	assign hdr_bad = hdch[hidx] &&
	                 ((rbyte ^ chhd[{hidx, 3'h0} +: 8]) &
	                  hden[{hidx, 3'h0} +: 8]) != 8'h00 &&
	                 !(bcen[hidx] && rbyte == 8'hff);
	assign rnf     = next_fld(rst_q,
	                 (rst_q == rpq_pkg::S_LEN) ? rbyte : pklen, 1'b0);
	assign fend    = bdone && ((rst_q == rpq_pkg::S_HDR &&
	                 rcnt_nx == {5'h0, hdlen}) || rst_q == rpq_pkg::S_LEN ||
	                 (rst_q == rpq_pkg::S_DATA && rcnt_nx == rxplen_q));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_q      <= rpq_pkg::S_PRE;
			rsh_q      <= 32'h0;
			rlfsr_q    <= `RPQ_PN9_SEED;
			pre_cnt_q  <= 8'h0;
			rcnt_q     <= 8'h0;
			win_q      <= 6'h0;
			tmo_q      <= 6'h0;
			rbits_q    <= 3'h0;
			rhalf_q    <= 1'b0;
			rfirst_q   <= 1'b0;
			rlast_q    <= 1'b0;
			inv_done_q <= 1'b0;
			tmo_run_q  <= 1'b0;
			rxhd_q     <= 32'h0;
			rxplen_q   <= 8'h0;
			rx_byte    <= 8'h0;
			rx_valid   <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_en) begin
				rst_q      <= rpq_pkg::S_PRE;
				rhalf_q    <= 1'b0;
				pre_cnt_q  <= 8'h0;
				win_q      <= 6'h0;
				inv_done_q <= 1'b0;
			end else if (sym_tick && manch && !rhalf_q) begin
				rfirst_q <= rx_sym;
				rhalf_q  <= 1'b1;
			end else if (rx_stb) begin
				rhalf_q   <= 1'b0;
				rsh_q     <= {rsh_q[30:0], rb_in};
				rlast_q   <= rx_b;
				pre_cnt_q <= pre_nx;
				rbits_q   <= rbits_q + 3'h1;
				if (rst_q == rpq_pkg::S_DATA)
					rlfsr_q <= {rlfsr_q[0] ^ rlfsr_q[5], rlfsr_q[8:1]};
				case (rst_q)
				rpq_pkg::S_PRE: begin
					if (win_q != 6'h3f)
						win_q <= win_q + 6'h01;
					// a valid preamble detection opens the sync search
					if (pre_hit) begin
						rst_q     <= rpq_pkg::S_SYNC;
						tmo_run_q <= 1'b0;
						tmo_q     <= 6'h0;
					end else if (inv_hit)
						inv_done_q <= 1'b1;
				end
				rpq_pkg::S_SYNC: begin
					if (sync_hit) begin
						rst_q    <= rnf;
						rbits_q  <= 3'h0;
						rcnt_q   <= 8'h0;
						rxplen_q <= pklen;
						rlfsr_q  <= `RPQ_PN9_SEED;
					// timer runs from the first non-preamble bit
					end else if (tmo_run_q || rx_b == rlast_q) begin
						tmo_run_q <= 1'b1;
						tmo_q     <= tmo_q + 6'h01;
						// timeout goes back to preamble search
						if (tmo_hit) begin
							rst_q      <= rpq_pkg::S_PRE;
							win_q      <= 6'h0;
							inv_done_q <= 1'b0;
						end
					end
				end
				rpq_pkg::S_HDR, rpq_pkg::S_LEN, rpq_pkg::S_DATA: begin
					if (bdone) begin
						rcnt_q <= rcnt_nx;
						if (rst_q == rpq_pkg::S_HDR)
							rxhd_q[{hidx, 3'h0} +: 8] <= rbyte;
						if (rst_q == rpq_pkg::S_LEN)
							rxplen_q <= rbyte;
						if (rst_q == rpq_pkg::S_DATA) begin
							rx_byte  <= rbyte;
							rx_valid <= 1'b1;
						end
					end
					if (bdone && rst_q == rpq_pkg::S_HDR && hdr_bad) begin
						rst_q      <= rpq_pkg::S_PRE;
						win_q      <= 6'h0;
						inv_done_q <= 1'b0;
					end else if (fend) begin
						rcnt_q <= 8'h0;
						rst_q  <= (rnf == rpq_pkg::S_IDLE) ?
						          rpq_pkg::S_PRE : rnf;
						win_q      <= 6'h0;
						inv_done_q <= 1'b0;
						rlfsr_q    <= `RPQ_PN9_SEED;
					end
				end
				default: rst_q <= rpq_pkg::S_PRE;
				endcase
			end
		end
	end

	// CRC feed: start pulse, then bits in scope
	logic rx_in_scope, tx_in_scope;
	// length and header in scope unless payload only
	assign tx_in_scope = tst_q == rpq_pkg::S_DATA || (!crcdonly &&
	                     (tst_q == rpq_pkg::S_HDR || tst_q == rpq_pkg::S_LEN));
	assign rx_in_scope = rst_q == rpq_pkg::S_DATA || (!crcdonly &&
	                     (rst_q == rpq_pkg::S_HDR || rst_q == rpq_pkg::S_LEN));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_clr <= 1'b0;
			crc_stb <= 1'b0;
			crc_bit <= 1'b0;
			pre_det <= 1'b0;
			pre_inv <= 1'b0;
		end else begin
			crc_clr <= tx_go || (rx_stb && rst_q == rpq_pkg::S_SYNC && sync_hit);
			crc_stb <= (tstep && tx_in_scope) || (rx_stb && rx_in_scope);
			crc_bit <= tstep ? tb : rb_in;
			// detector level on an output pin
			pre_det <= rx_en && rst_q != rpq_pkg::S_PRE;
			pre_inv <= rx_en && inv_done_q && rst_q == rpq_pkg::S_PRE;
		end
	end

	// Status flags clear on read; a new event wins over the clear
	logic [7:0] set1, set2, clr1, clr2;
	assign set1 = {5'h0, tx_done,
	               rx_stb && fend && rnf == rpq_pkg::S_IDLE &&
	               !(rst_q == rpq_pkg::S_HDR && hdr_bad),
	               rx_stb && bdone && rst_q == rpq_pkg::S_HDR && hdr_bad};
	assign set2 = {rx_stb && rst_q == rpq_pkg::S_SYNC && sync_hit, 5'h0,
	               rx_stb && rst_q == rpq_pkg::S_PRE && pre_hit,
	               rx_stb && rst_q == rpq_pkg::S_PRE && inv_hit && !pre_hit};
	// only bits actually returned are cleared
	assign clr1 = (rd_done && idx == `RPQ_IX_ST1) ? prdata[7:0] : 8'h00;
	assign clr2 = (rd_done && idx == `RPQ_IX_ST2) ? prdata[7:0] : 8'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st1_q <= 8'h00;
			st2_q <= 8'h00;
		end else begin
			st1_q <= (st1_q & ~clr1) | set1;
			// found preamble wins over an invalid one in the same cycle
			st2_q <= (st2_q & ~clr2) | set2;
		end
	end
endmodule
`default_nettype wire

// file: verif/rpq_air.sv
// Remote radio: sends symbols to the receiver, records transmitted ones
`timescale 1ns/100ps
`default_nettype none
module rpq_air (
	input  wire logic pclk,
	input  wire logic sym_tick,
	output logic      rx_sym,
	input  wire logic tx_sym,
	input  wire logic tx_active,
	input  wire logic crc_stb,
	input  wire logic crc_bit,
	input  wire logic tx_rd,
	input  wire logic tx_rewind
);
	logic [63:0] sh = 0, sv = 0;
	logic        tk = 0, act_q = 0;
	int          cnt = 0, ncrc = 0, nrew = 0, nrd = 0, nones = 0;
	initial rx_sym = 1'b0;
	always @(posedge pclk) begin
		// Idle line toggles so a stale level never passes for data
		if (sym_tick)
			rx_sym <= cnt > 0 ? sh[cnt-1] : !rx_sym;
		if (sym_tick && cnt > 0)
			cnt <= cnt - 1;
		tk <= sym_tick && tx_active;
		act_q <= tx_active;
		if (tx_active && !act_q) begin
			sv = 64'h0;
			ncrc = 0;
			nrd = 0;
			nones = 0;
		end
		if (tk)
			sv = {sv[62:0], tx_sym};
		if (crc_stb)
			ncrc++;
		// Ones fed to the CRC tell whether the clear bits were sent
		if (crc_stb && crc_bit)
			nones++;
		if (tx_rd)
			nrd++;
		if (tx_rewind)
			nrew++;
	end
	task automatic send(input logic [63:0] b, input int n);
		@(posedge pclk);
		sh <= b;
		cnt <= n;
		@(posedge pclk);
		wait (cnt == 0);
		repeat (3) @(posedge pclk iff sym_tick);
	endtask
endmodule
`default_nettype wire

// file: verif/rpq_monitor.sv
// Checker of the qualifier's port behaviour
`timescale 1ns/100ps
`default_nettype none
module rpq_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sym_tick,
	input wire logic        rx_en,
	input wire logic        tx_sym,
	input wire logic        tx_active,
	input wire logic        crc_clr,
	input wire logic        rx_valid,
	input wire logic        pre_det
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_s;
		psel && penable && !pready;
	endsequence
	sequence off_s;
		!rx_en [*2];
	endsequence
	pready_wait_a: assert property (acc_s |=> pready)
		else $error("late ready");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	unmapped_err_a: assert property (acc_s ##0 paddr[11:9] != 3'h0
		|=> pslverr && prdata == 32'h0) else $error("no error");
	rdata_hi_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper data set");
	txsym_tick_a: assert property (tx_active && $changed(tx_sym)
		|-> $past(sym_tick)) else $error("symbol off tick");
	tx_start_a: assert property ($rose(tx_active)
		|-> crc_clr ##0 tx_active [*8]) else $error("short frame");
	rxvalid_one_a: assert property (rx_valid |=> !rx_valid)
		else $error("valid held");
	rxoff_idle_a: assert property (off_s |-> !pre_det)
		else $error("detect while off");
endmodule
bind rpq_top rpq_monitor rpq_monitor_inst (.pclk, .presetn, .paddr,
	.psel, .penable, .prdata, .pready, .pslverr, .sym_tick, .rx_en,
	.tx_sym, .tx_active, .crc_clr, .rx_valid, .pre_det);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the radio packet qualifier
`timescale 1ns/100ps
`default_nettype none
`include "rpq_consts.svh"
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        sym_tick = 0, rx_en = 0, tx_wr = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, v;
	logic [7:0]  tx_byte = 8'ha5, tx_level = 0, rx_byte, got;
	logic        pready, pslverr, rx_sym, tx_sym, tx_active, tx_rd;
	logic        tx_rewind, rx_valid, crc_clr, crc_stb, crc_bit;
	logic        pre_det, pre_inv;
	logic [1:0]  tdiv = 0;
	logic [63:0] x;
	int          bad_count = 0, checks_done = 0, cyc = 0, ngot, k, i;
	logic [6:0]  ixs [9] = '{`RPQ_IX_HC1, `RPQ_IX_HC2, `RPQ_IX_PRE,
		`RPQ_IX_PDC, `RPQ_IX_SYNC3, `RPQ_IX_SYNC2, `RPQ_IX_SYNC1,
		`RPQ_IX_HDEN3, `RPQ_IX_HDEN0};
	logic [7:0]  rst [9] = '{`RPQ_RST_HC1, `RPQ_RST_HC2, `RPQ_RST_PRE,
		`RPQ_RST_PDC, `RPQ_RST_SYNC3, `RPQ_RST_SYNC2, 8'h00,
		`RPQ_RST_HDEN, `RPQ_RST_HDEN};
	// Modulation mode over data access control
	logic [15:0] md [4] = '{16'h0000, 16'h0120, 16'h0200, 16'h0620};
	// Header, header control, header enable, accepted
	logic [31:0] cs [5] = '{32'h3c08ff01, 32'h3d08ff00, 32'hff88ff01,
		32'hff08ff00, 32'h5c080f01};
	rpq_top rpq_top_inst (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .sym_tick, .rx_sym,
		.rx_en, .tx_byte, .tx_wr, .tx_level, .tx_sym, .tx_active, .tx_rd,
		.tx_rewind, .rx_byte, .rx_valid, .crc_clr, .crc_stb, .crc_bit,
		.pre_det, .pre_inv);
	rpq_air rpq_air_inst (.pclk, .sym_tick, .rx_sym, .tx_sym, .tx_active,
		.crc_stb, .crc_bit, .tx_rd, .tx_rewind);
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		tdiv <= tdiv + 2'h1;
		sym_tick <= tdiv == 2'h3;
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) begin
			got <= rx_byte;
			ngot <= ngot + 1;
		end
		if (cyc == 30000) begin
			bad_count++;
			final_report();
		end
	end
	task chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [6:0] ix, input logic [7:0] d);
		apb(1'b1, {3'h0, ix, 2'h0}, d);
	endtask
	task rd(input logic [6:0] ix, input logic [7:0] m, x, input string s);
		apb(1'b0, {3'h0, ix, 2'h0}, 8'h00);
		chk((r[7:0] & m) === x && r[31:8] === 24'h0, s);
	endtask
	// Dropping the enable clears any search left over
	task rx_on();
		@(posedge pclk) rx_en <= 1'b0;
		repeat (4) @(posedge pclk);
		rx_en <= 1'b1;
		ngot = 0;
	endtask
	task final_report();
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 9; k++)
			rd(ixs[k], 8'hff, rst[k], "reset value");
		wr(`RPQ_IX_RXHD3, 8'h55);
		rd(`RPQ_IX_RXHD3, 8'hff, 8'h00, "read-only");
		apb(1'b0, 12'h800, 8'h00);
		chk(e === 1'b1 && r === 32'h0, "unmapped");
		wr(`RPQ_IX_PRE, 8'h01);
		wr(`RPQ_IX_HC2, 8'h18);
		wr(`RPQ_IX_TXHD3, 8'hc3);
		wr(`RPQ_IX_PKLEN, 8'h01);
		// Long preambles below, so the 20-bit threshold is kept
		wr(`RPQ_IX_PDC, `RPQ_RST_PDC);
		wr(`RPQ_IX_CHHD3, 8'h3c);
		@(posedge pclk) tx_wr <= 1'b1;
		@(posedge pclk) tx_wr <= 1'b0;
		for (k = 0; k < 4; k++) begin
			wr(`RPQ_IX_MOD, md[k][15:8]);
			wr(`RPQ_IX_DAC, md[k][7:0]);
			wr(`RPQ_IX_CTRL1, 8'h08);
			wait (tx_active === 1'b1);
			wait (tx_active === 1'b0);
			repeat (8) @(posedge pclk);
			v = {8'h55, 8'h2d, 8'hc3, md[k][8] ? 8'h5a : 8'ha5};
			x = {32'h0, v};
			if (md[k][9])
				for (i = 31; i >= 0; i--)
					x = {x[61:0], v[i] ^ md[k][10], !v[i] ^ md[k][10]};
			chk(x === rpq_air_inst.sv, "symbols");
			chk(rpq_air_inst.ncrc == (md[k][5] ? 8 : 16), "crc");
			chk(rpq_air_inst.nones == (md[k][5] ? 4 : 8), "crc bits");
			chk(rpq_air_inst.nrd == 1, "pops");
			rd(`RPQ_IX_ST1, 8'h04, 8'h04, "sent");
		end
		chk(rpq_air_inst.nrew == 3, "resend");
		wr(`RPQ_IX_MOD, 8'h00);
		wr(`RPQ_IX_AFTHR, 8'h05);
		wr(`RPQ_IX_CTRL2, 8'h08);
		@(posedge pclk) tx_level <= 8'h05;
		repeat (20) @(posedge pclk);
		chk(tx_active === 1'b0, "early start");
		tx_level <= 8'h06;
		wait (tx_active === 1'b1);
		@(posedge pclk) tx_level <= 8'h00;
		wr(`RPQ_IX_CTRL2, 8'h00);
		wait (tx_active === 1'b0);
		rd(`RPQ_IX_ST1, 8'h04, 8'h04, "auto sent");
		for (k = 0; k < 5; k++) begin
			wr(`RPQ_IX_HC1, cs[k][23:16]);
			wr(`RPQ_IX_HDEN3, cs[k][15:8]);
			rx_on();
			rpq_air_inst.send({40'h5555555555, 8'h2d, cs[k][31:24], 8'h81}, 64);
			repeat (8) @(posedge pclk);
			chk(ngot == cs[k][0] && (!cs[k][0] || got === 8'h81), "data");
			rd(`RPQ_IX_ST1, 8'h03, cs[k][0] ? 8'h02 : 8'h01, "rx");
			rd(`RPQ_IX_ST2, 8'h82, 8'h82, "sync");
			rd(`RPQ_IX_RXHD3, 8'hff, cs[k][31:24], "header");
		end
		rx_on();
		rpq_air_inst.send({40'h5555555555, 24'h0}, 64);
		chk(pre_det === 1'b0, "timeout");
		rd(`RPQ_IX_ST2, 8'h82, 8'h02, "no sync");
		wr(`RPQ_IX_INVW, 8'h20);
		rx_on();
		rpq_air_inst.send(64'hffff, 16);
		chk(pre_inv === 1'b1, "invalid");
		rd(`RPQ_IX_ST2, 8'h01, 8'h01, "invalid flag");
		final_report();
	end
endmodule
`default_nettype wire
